// [design/prhm_fifo.sv]
// parameterised valid/ready fifo for output octets
`timescale 1ns/1ns
module prhm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic flush, // drop all contents
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // head word, registered
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic wr, rd;
  // handshakes
  assign in_ready = (cnt_r != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (cnt_r != '0) && !flush;
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;
  // pointer next values
  always_comb
  begin
    wp_nxt = wr ? wp_r + AW'(1) : wp_r;
    rp_nxt = rd ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    if (flush)
    begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end
  // pointer registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // storage, no reset needed
  always_ff @(posedge clk_sys)
  begin
    if (wr)
    begin
      mem_r[wp_r] <= in_data;
    end
  end
  // head word register, tracks read pointer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      out_data <= '0;
    end
    else if (wr && (cnt_nxt == (AW+1)'(1)) && (cnt_r == '0 || rd))
    begin
      out_data <= in_data;
    end
    else
    begin
      out_data <= mem_r[rp_nxt];
    end
  end
endmodule

// [design/prhm_pkg.sv]
// constants and types shared by the random generator health monitor
package prhm_pkg;
  // ---------------------------------------------------------------
  // timing and test constants
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000; // system clock rate
  localparam int unsigned SAMPLE_NS = 500; // raw bit sample period
  localparam int unsigned SAMPLE_CYC = (SAMPLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned STUCK_RUN = 32; // equal bits in a row beyond this = total failure
  localparam int unsigned WIN_BITS = 256; // online test window length
  localparam int unsigned ONES_LO = 96; // min ones per window
  localparam int unsigned ONES_HI = 160; // max ones per window
  localparam int unsigned CHI_OCT = 16; // octets per chi-square block
  localparam int unsigned CHI_MAX = 40; // max chi statistic (scaled)
  localparam int unsigned FIFO_DEPTH = 16; // octet buffer depth
  localparam int unsigned OCT_W = 8; // octet width
  // ---------------------------------------------------------------
  // monitor states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_FAIL} prhm_state_t;
endpackage

// [design/prhm_top.sv]
// physical random generator with total-failure and online health tests
`timescale 1ns/1ns
module prhm_top #(
  parameter int unsigned WIN_BITS = prhm_pkg::WIN_BITS, // online window
  parameter int unsigned STUCK_RUN = prhm_pkg::STUCK_RUN // failure run length
) (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic nrst, // async reset, active low
  input wire logic raw_bit, // noise source bit, asynchronous
  input wire logic rng_start, // start generator, level
  output logic [7:0] oct_data, // random octet
  output logic oct_valid, // octet valid
  input wire logic oct_ack, // consumer takes octet
  output logic test_pass, // health test pass indication
  output logic test_fail, // health test fail indication
  output logic [7:0] seed_data, // seed octet for deterministic_generator
  output logic seed_valid, // seed octet valid, one pulse
  input wire logic det_seeded, // deterministic_generator holds a seed
  input wire logic det_request, // software asks for pseudo-random data
  output logic sec_reset // security reset request, pulse
);
  // ---------------------------------------------------------------
  // input synchroniser and sample enable
  // ---------------------------------------------------------------
  logic [2:0] sync_r, sync_nxt;
  logic bit_r, bit_nxt; // filtered raw bit
  logic [7:0] div_r, div_nxt;
  logic smp; // one-cycle sample enable
  // synchroniser and divider next values
  always_comb
  begin
    sync_nxt = {sync_r[1:0], raw_bit};
    bit_nxt = (sync_r[2] == sync_r[1]) ? sync_r[2] : bit_r;
    div_nxt = (div_r == 8'(prhm_pkg::SAMPLE_CYC - 1)) ? 8'h00 : div_r + 8'h01;
    if (!rng_start)
    begin
      div_nxt = 8'h00;
    end
  end
  assign smp = rng_start && (div_r == 8'(prhm_pkg::SAMPLE_CYC - 1));
  // synchroniser registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_r <= 3'h0;
      bit_r <= 1'b0;
      div_r <= 8'h00;
    end
    else
    begin
      sync_r <= sync_nxt;
      bit_r <= bit_nxt;
      div_r <= div_nxt;
    end
  end
  // ---------------------------------------------------------------
  // health tests and octet assembly
  // ---------------------------------------------------------------
  prhm_pkg::prhm_state_t st_r, st_nxt;
  logic prev_r, prev_nxt; // last sampled bit
  logic [7:0] run_r, run_nxt; // equal-bit run length
  logic [9:0] wcnt_r, wcnt_nxt; // bits in window
  logic [9:0] ones_r, ones_nxt; // ones in window
  logic [7:0] sh_r, sh_nxt; // octet shift register
  logic [2:0] bcnt_r, bcnt_nxt; // bits in octet
  logic oct_rdy; // full octet this cycle
  logic stuck, win_end, win_bad;
  logic push; // octet into fifo
  logic fifo_in_ready;
  // failure and window detection
  always_comb
  begin
    stuck = smp && (bit_r == prev_r) && (run_r >= 8'(STUCK_RUN - 1));
    win_end = smp && (wcnt_r == 10'(WIN_BITS - 1));
    win_bad = (ones_r + 10'(bit_r) < 10'(prhm_pkg::ONES_LO))
      || (ones_r + 10'(bit_r) > 10'(prhm_pkg::ONES_HI));
  end
  // test state next values
  always_comb
  begin
    st_nxt = st_r;
    prev_nxt = prev_r;
    run_nxt = run_r;
    wcnt_nxt = wcnt_r;
    ones_nxt = ones_r;
    sh_nxt = sh_r;
    bcnt_nxt = bcnt_r;
    oct_rdy = 1'b0;
    if (smp && st_r != prhm_pkg::ST_FAIL)
    begin
      // bit sampled: update run, window and octet
      prev_nxt = bit_r;
      run_nxt = (bit_r == prev_r) ? run_r + 8'h01 : 8'h00;
      wcnt_nxt = win_end ? 10'h000 : wcnt_r + 10'h001;
      ones_nxt = win_end ? 10'h000 : ones_r + 10'(bit_r);
      sh_nxt = {sh_r[6:0], bit_r};
      bcnt_nxt = bcnt_r + 3'h1;
      oct_rdy = (bcnt_r == 3'h7);
      if (stuck || (win_end && win_bad))
      begin
        st_nxt = prhm_pkg::ST_FAIL;
      end
      else if (win_end && st_r == prhm_pkg::ST_STARTUP)
      begin
        st_nxt = prhm_pkg::ST_RUN;
      end
    end
    if (!rng_start)
    begin
      // generator stopped: restart tests from scratch
      st_nxt = prhm_pkg::ST_STARTUP;
      run_nxt = 8'h00;
      wcnt_nxt = 10'h000;
      ones_nxt = 10'h000;
      bcnt_nxt = 3'h0;
    end
  end
  // test state registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= prhm_pkg::ST_STARTUP;
      prev_r <= 1'b0;
      run_r <= 8'h00;
      wcnt_r <= 10'h000;
      ones_r <= 10'h000;
      sh_r <= 8'h00;
      bcnt_r <= 3'h0;
    end
    else
    begin
      st_r <= st_nxt;
      prev_r <= prev_nxt;
      run_r <= run_nxt;
      wcnt_r <= wcnt_nxt;
      ones_r <= ones_nxt;
      sh_r <= sh_nxt;
      bcnt_r <= bcnt_nxt;
    end
  end
  // only octets from a healthy run are pushed, fifo room is not checked
  assign push = oct_rdy && (st_r == prhm_pkg::ST_RUN) && (st_nxt == prhm_pkg::ST_RUN);
  // status flags
  assign test_pass = (st_r == prhm_pkg::ST_RUN);
  assign test_fail = (st_r == prhm_pkg::ST_FAIL);
  // ---------------------------------------------------------------
  // output fifo, flushed on any failure
  // ---------------------------------------------------------------
  prhm_fifo #(
    .WIDTH(prhm_pkg::OCT_W),
    .DEPTH(prhm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .flush(st_r != prhm_pkg::ST_RUN),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(sh_nxt),
    .out_valid(oct_valid),
    .out_ready(oct_ack),
    .out_data(oct_data)
  );
  // ---------------------------------------------------------------
  // chi-square test on seed blocks
  // ---------------------------------------------------------------
  logic [5:0] hist_r [16]; // nibble histogram, a bin may reach all 32 nibbles
  logic [5:0] hist_nxt [16];
  logic [4:0] ocnt_r, ocnt_nxt; // octets in block
  logic [7:0] sbuf_r, sbuf_nxt; // last seed octet
  logic sv_r, sv_nxt;
  logic [9:0] chi; // sum of squared deviations
  logic tap; // octet sampled for seeding
  // every healthy octet feeds the statistic, even when the fifo drops it
  assign tap = push;
  // statistic: sum of (count-2)^2 over 16 bins of 32 nibbles
  always_comb
  begin
    chi = 10'h000;
    for (int i = 0; i < 16; i++)
    begin
      // squares wrap modulo 1024, exact since the sum never exceeds 960
      chi = chi + ((10'(hist_r[i]) - 10'h002) * (10'(hist_r[i]) - 10'h002));
    end
  end
  // histogram next values
  always_comb
  begin
    hist_nxt = hist_r;
    ocnt_nxt = ocnt_r;
    sbuf_nxt = sbuf_r;
    sv_nxt = 1'b0;
    if (tap)
    begin
      hist_nxt[sh_nxt[3:0]] = hist_r[sh_nxt[3:0]] + 6'h01;
      hist_nxt[sh_nxt[7:4]] = hist_nxt[sh_nxt[7:4]] + 6'h01;
      ocnt_nxt = ocnt_r + 5'h01;
      sbuf_nxt = sh_nxt;
    end
    if (ocnt_r == 5'(prhm_pkg::CHI_OCT))
    begin
      // block closed: seed only on a passing statistic
      sv_nxt = (chi <= 10'(prhm_pkg::CHI_MAX)) && test_pass;
      ocnt_nxt = 5'h00;
      for (int i = 0; i < 16; i++)
      begin
        hist_nxt[i] = 6'h00;
      end
    end
  end
  // histogram registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 16; i++)
      begin
        hist_r[i] <= 6'h00;
      end
      ocnt_r <= 5'h00;
      sbuf_r <= 8'h00;
      sv_r <= 1'b0;
    end
    else
    begin
      hist_r <= hist_nxt;
      ocnt_r <= ocnt_nxt;
      sbuf_r <= sbuf_nxt;
      sv_r <= sv_nxt;
    end
  end
  assign seed_data = sbuf_r;
  assign seed_valid = sv_r;
  // ---------------------------------------------------------------
  // unseeded request guard
  // ---------------------------------------------------------------
  logic sr_r, sr_nxt;
  // request while unseeded raises a security reset pulse
  always_comb
  begin
    sr_nxt = det_request && !det_seeded;
  end
  // guard register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sr_r <= 1'b0;
    end
    else
    begin
      sr_r <= sr_nxt;
    end
  end
  assign sec_reset = sr_r;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_NO_OUT_FAIL: assert property (@(posedge clk_sys) disable iff (!nrst)
    test_fail |-> !oct_valid) else $error("octet valid while failed");
  AST_STUCK_FAILS: assert property (@(posedge clk_sys) disable iff (!nrst)
    (stuck && rng_start && st_r != prhm_pkg::ST_FAIL) |=> test_fail)
    else $error("stuck source not flagged");
  AST_NO_OUT_START: assert property (@(posedge clk_sys) disable iff (!nrst)
    !test_pass |=> !push) else $error("octet before startup pass");
  AST_PASS_ONLY_WIN: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(test_pass) |-> $past(win_end)) else $error("pass without window end");
  AST_WIN_BOUND: assert property (@(posedge clk_sys) disable iff (!nrst)
    wcnt_r < 10'(WIN_BITS)) else $error("window overrun");
  AST_BAD_WIN: assert property (@(posedge clk_sys) disable iff (!nrst)
    (win_end && win_bad && rng_start && !test_fail) |=> test_fail)
    else $error("biased window not flagged");
  AST_PASS_XOR: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(test_pass && test_fail)) else $error("pass and fail together");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
    (oct_valid && !oct_ack && test_pass) ##1 test_pass |-> oct_valid && $stable(oct_data))
    else $error("octet changed before ack");
  AST_OCTET: assert property (@(posedge clk_sys) disable iff (!nrst)
    push |-> bcnt_r == 3'h7) else $error("partial octet pushed");
  AST_SEED: assert property (@(posedge clk_sys) disable iff (!nrst)
    seed_valid |-> $past(chi) <= 10'(prhm_pkg::CHI_MAX)) else $error("seed without chi pass");
  AST_SECRST: assert property (@(posedge clk_sys) disable iff (!nrst)
    (det_request && !det_seeded) |=> sec_reset) else $error("no security reset");
  COV_PASS: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(test_pass));
  COV_FAIL: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(test_fail));
  COV_READ: cover property (@(posedge clk_sys) disable iff (!nrst) oct_valid && oct_ack);
  COV_SEED: cover property (@(posedge clk_sys) disable iff (!nrst) seed_valid);
endmodule

// [dv/prhm_sw_model.sv]
// software side model that reads random octets from the generator
`timescale 1ns/1ns
module prhm_sw_model (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic oct_valid, // octet available
  input wire logic [7:0] oct_data, // random octet
  output logic oct_ack, // take octet
  input wire logic stall, // hold off reading
  output logic [15:0] rx_count, // octets taken
  output logic [15:0] bad_count // octets off the source pattern
);
  // ----------------------------------------------------------
  // read side
  // ----------------------------------------------------------
  // ready level follows stall, updated on the rising edge after the design has sampled it
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      oct_ack <= 1'b0;
    else
      oct_ack <= !stall;
  end
  // count whole octets taken; alternating source gives four shapes
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_count <= 16'h0000;
      bad_count <= 16'h0000;
    end
    else if (oct_valid && oct_ack)
    begin
      rx_count <= rx_count + 16'h0001;
      if (!(oct_data inside {8'hcc, 8'h66, 8'h33, 8'h99}))
        bad_count <= bad_count + 16'h0001;
    end
  end
endmodule

// [dv/tb_physical_rng_health_monitor.sv]
// self-checking testbench for the random generator health monitor
`timescale 1ns/1ns
module tb_physical_rng_health_monitor;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic clk_sys = 1'b0; // system clock
  logic nrst = 1'b0; // reset, active low
  logic raw_bit = 1'b0; // noise bit to design
  logic rng_start = 1'b0; // generator run level
  logic det_seeded = 1'b0; // seeded flag
  logic det_request = 1'b0; // pseudo-random request
  logic stall = 1'b0; // reader hold off
  logic [7:0] oct_data, seed_data; // octet outputs
  logic oct_valid, oct_ack, test_pass, test_fail, seed_valid, sec_reset;
  logic [15:0] rx_count, bad_count; // reader counts
  int mismatches = 0; // failed comparisons
  int checks = 0; // comparisons made
  int src_mode = 0; // 0 alternate, 1 ones, 2 zeros, 3 biased
  int src_cnt = 0; // source cycle counter
  always #50 clk_sys = ~clk_sys;
  // ----------------------------------------------------------
  // design and reader
  // ----------------------------------------------------------
  prhm_top #(.WIN_BITS(256), .STUCK_RUN(8)) uut (.clk_sys(clk_sys), .nrst(nrst),
    .raw_bit(raw_bit), .rng_start(rng_start), .oct_data(oct_data), .oct_valid(oct_valid),
    .oct_ack(oct_ack), .test_pass(test_pass), .test_fail(test_fail),
    .seed_data(seed_data), .seed_valid(seed_valid), .det_seeded(det_seeded),
    .det_request(det_request), .sec_reset(sec_reset));
  prhm_sw_model sw (.clk_sys(clk_sys), .nrst(nrst), .oct_valid(oct_valid),
    .oct_data(oct_data), .oct_ack(oct_ack), .stall(stall), .rx_count(rx_count),
    .bad_count(bad_count));
  // noise source: each bit held 10 cycles, two samples apiece
  always @(negedge clk_sys)
  begin
    src_cnt <= src_cnt + 1;
    case (src_mode)
      0: raw_bit <= ((src_cnt / 10) % 2) == 1;
      1: raw_bit <= 1'b1;
      2: raw_bit <= 1'b0;
      default: raw_bit <= ((src_cnt / 10) % 4) != 0;
    endcase
  end
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic chk1(input string nm, input logic exp, input logic got);
    checks++;
    if (exp !== got)
    begin
      mismatches++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chkv(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (exp !== got)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // wait at falling edges for pass (0), fail (1) or octet (2)
  task automatic wait_on(input int which, input int lim, output logic hit);
    hit = 1'b0;
    repeat (lim)
    begin
      @(negedge clk_sys);
      if ((which == 0 && test_pass === 1'b1) || (which == 1 && test_fail === 1'b1) ||
          (which == 2 && oct_valid === 1'b1))
      begin
        hit = 1'b1;
        break;
      end
    end
  endtask
  // drop and raise the run level to restart the tests
  task automatic restart(input int mode);
    @(negedge clk_sys);
    rng_start = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk1("test_fail cleared", 1'b0, test_fail);
    src_mode = mode;
    rng_start = 1'b1;
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    chk1("test_pass", 1'b0, test_pass);
    chk1("oct_valid", 1'b0, oct_valid);
    chk1("seed_valid", 1'b0, seed_valid);
    chk1("sec_reset", 1'b0, sec_reset);
    $display("test reset done");
  endtask
  task automatic t_startup();
    logic hit;
    logic early;
    early = 1'b0;
    src_mode = 0;
    rng_start = 1'b1;
    repeat (1200)
    begin
      @(negedge clk_sys);
      early = early | oct_valid | test_pass;
    end
    chk1("output before pass", 1'b0, early);
    wait_on(0, 400, hit);
    chk1("test_pass", 1'b1, hit);
    chk1("test_fail", 1'b0, test_fail);
    wait_on(2, 120, hit);
    chk1("oct_valid", 1'b1, hit);
    $display("test startup done");
  endtask
  task automatic t_hold_fill();
    logic [7:0] held;
    logic moved;
    logic hit;
    int seeds;
    int base;
    moved = 1'b0;
    seeds = 0;
    stall = 1'b1;
    wait_on(2, 120, hit);
    chk1("oct_valid", 1'b1, hit);
    held = oct_data;
    repeat (1000)
    begin
      @(negedge clk_sys);
      moved = moved | (oct_data !== held) | !oct_valid;
      seeds = seeds + seed_valid;
    end
    chk1("octet held", 1'b0, moved);
    chkv("seed pulses", 16'h0000, 16'(seeds));
    chk1("seed_data shape", 1'b1, seed_data inside {8'hcc, 8'h66, 8'h33, 8'h99});
    base = rx_count;
    stall = 1'b0;
    repeat (17) @(negedge clk_sys);
    chkv("drained", 16'h0010, 16'(rx_count - base));
    chkv("bad octets", 16'h0000, bad_count);
    $display("test hold and fill done");
  endtask
  task automatic t_stuck();
    logic hit;
    logic leak;
    leak = 1'b0;
    src_mode = 1;
    wait_on(1, 100, hit);
    chk1("test_fail", 1'b1, hit);
    @(negedge clk_sys);
    chk1("test_pass", 1'b0, test_pass);
    src_mode = 0;
    repeat (2000)
    begin
      @(negedge clk_sys);
      leak = leak | oct_valid | !test_fail;
    end
    chk1("output after fail", 1'b0, leak);
    $display("test stuck done");
  endtask
  task automatic t_dead_start();
    logic hit;
    int base;
    base = rx_count;
    restart(2);
    wait_on(1, 100, hit);
    chk1("test_fail", 1'b1, hit);
    repeat (1500) @(negedge clk_sys);
    chkv("octets from dead source", 16'(base), rx_count);
    $display("test dead start done");
  endtask
  task automatic t_bias();
    logic hit;
    restart(0);
    wait_on(0, 1700, hit);
    chk1("test_pass", 1'b1, hit);
    src_mode = 3;
    wait_on(1, 2700, hit);
    chk1("test_fail", 1'b1, hit);
    @(negedge clk_sys);
    chk1("oct_valid", 1'b0, oct_valid);
    $display("test bias done");
  endtask
  task automatic t_sec_reset();
    int n;
    for (int s = 0; s < 2; s++)
    begin
      n = 0;
      det_seeded = s[0];
      det_request = 1'b1;
      @(negedge clk_sys);
      det_request = 1'b0;
      n = n + sec_reset;
      repeat (4)
      begin
        @(negedge clk_sys);
        n = n + sec_reset;
      end
      chkv("sec_reset pulses", s == 0 ? 16'h0001 : 16'h0000, 16'(n));
    end
    $display("test security reset done");
  endtask
  // ----------------------------------------------------------
  // run control
  // ----------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_startup();
    t_hold_fill();
    t_stuck();
    t_dead_start();
    t_bias();
    t_sec_reset();
    wrap_up();
  end
  // watchdog well beyond the roughly 8600 cycles of the tests
  initial
  begin
    #3_000_000;
    mismatches++;
    wrap_up();
  end
endmodule
